// ==== rtl/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
    // register byte offsets on the bus
    localparam logic [3:0] OFF_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFF_CTRL_TWO = 4'h4;
    localparam logic [3:0] OFF_CHAN_SEL = 4'h8;
    localparam logic [3:0] OFF_RESULT = 4'hC;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // control register one fields
    localparam int B_ON = 15;
    localparam int B_IDLE_STOP = 13;
    localparam int B_DMA_ORDER = 12;
    localparam int B_RES = 10;
    localparam int B_OUTPUT_FORMAT_LO = 8;
    localparam int B_SRC_LO = 5;
    localparam int B_AUTO = 2;
    localparam int B_SAMPLE_CONTROL = 1;
    localparam int B_DONE = 0;
    localparam logic [15:0] CTRL_ONE_WMASK = 16'hB7FC;

    // control register two fields
    localparam int B_BUFFER_FILL_MODE = 1;
    localparam int B_ALTERNATE_INPUT_MODE = 0;
    localparam logic [15:0] CTRL_TWO_WMASK = 16'h0003;

    // channel 1..3 select fields
    localparam int B_NEG_B_LO = 9;
    localparam int B_POS_B = 8;
    localparam int B_NEG_A_LO = 1;
    localparam int B_POS_A = 0;
    localparam logic [15:0] CHAN_SEL_WMASK = 16'h0707;

    // result buffer geometry
    localparam logic [1:0] SAMPLES_PER_IRQ_M1 = 2'h3;
    localparam logic [7:0] HALF_WORDS = 8'h04;
    localparam logic [7:0] DMA_BUF_WORDS = 8'h08;

    // analog source codes: pins 0..15, op amps 16..18, low reference
    localparam logic [4:0] SRC_OA1 = 5'h10;
    localparam logic [4:0] SRC_OA2 = 5'h11;
    localparam logic [4:0] SRC_OA3 = 5'h12;
    localparam logic [4:0] SRC_VREFL = 5'h1F;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_OFF, ST_SAMPLE, ST_CONVERT} conv_state_t;

    typedef struct packed {
        logic [4:0] pos;
        logic [4:0] neg;
    } route_t;

    typedef struct packed {
        logic [15:0] data;
        logic [7:0] addr;
    } result_t;
endpackage

// ==== rtl/adc_ctrl.sv ====
`timescale 1ns/1ps
module adc_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idle_mode,
    input wire logic [2:0] op_amp_enable,
    input wire logic conv_trigger,
    input wire logic conv_result_valid,
    input wire logic [11:0] conv_result_raw,
    input wire logic [1:0] conv_result_chan,
    output logic converter_active,
    output logic sample_active,
    output logic conv_start,
    output logic input_set_second,
    output adc_ctrl_pkg::route_t route_ch1,
    output adc_ctrl_pkg::route_t route_ch2,
    output adc_ctrl_pkg::route_t route_ch3,
    output logic dma_write_valid,
    output adc_ctrl_pkg::result_t dma_write,
    output logic buffer_irq
);
    import adc_ctrl_pkg::*;

    conv_state_t state_r, state_nxt;
    logic [15:0] ctrl1_r, ctrl1_nxt;
    logic [15:0] ctrl2_r, ctrl2_nxt;
    logic [15:0] chsel_r, chsel_nxt;
    logic sample_control_r, sample_control_nxt;
    logic done_r, done_nxt;
    logic alt_phase_r, alt_phase_nxt;
    logic half_r, half_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [15:0] last_r;
    logic dma_valid_r, irq_r;
    result_t dma_r;

    // bus slave state: address and data are parked until both have arrived
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [3:0] aw_addr_r;
    logic aw_bad_r;
    logic [15:0] wdata_r;
    logic [1:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire do_write = aw_held_r && w_held_r && !bvalid_r;
    wire [15:0] byte_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire wr_ctrl1 = do_write && !aw_bad_r && aw_addr_r == OFF_CTRL_ONE;
    wire wr_ctrl2 = do_write && !aw_bad_r && aw_addr_r == OFF_CTRL_TWO;
    wire wr_chsel = do_write && !aw_bad_r && aw_addr_r == OFF_CHAN_SEL;
    wire wr_low = wr_ctrl1 && wstrb_r[0];
    wire aw_unmapped = s_axi_awaddr[31:4] != 28'h0000000 || s_axi_awaddr[1:0] != 2'h0;
    wire ar_unmapped = s_axi_araddr[31:4] != 28'h0000000 || s_axi_araddr[1:0] != 2'h0;

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // control decode
    wire ctrl_on = ctrl1_r[B_ON];
    wire idle_stop = ctrl1_r[B_IDLE_STOP];
    wire dma_order = ctrl1_r[B_DMA_ORDER];
    wire res12 = ctrl1_r[B_RES];
    wire [1:0] output_format = ctrl1_r[B_OUTPUT_FORMAT_LO +: 2];
    wire [2:0] trig_src = ctrl1_r[B_SRC_LO +: 3];
    wire auto_sample = ctrl1_r[B_AUTO];
    wire buffer_fill_mode = ctrl2_r[B_BUFFER_FILL_MODE];
    wire alternate_input_mode = ctrl2_r[B_ALTERNATE_INPUT_MODE];
    wire run = ctrl_on && !(idle_stop && idle_mode);
    wire sw_sample_control_clear = wr_low && !wdata_r[B_SAMPLE_CONTROL];
    wire sw_done_clear = wr_low && !wdata_r[B_DONE];
    // manual source: software ends sampling, which starts the conversion
    wire start = sample_control_r && (trig_src == 3'h0 ? sw_sample_control_clear : conv_trigger);
    wire result_fire = state_r == ST_CONVERT && run && conv_result_valid;
    wire irq_now = result_fire && cnt_r == SAMPLES_PER_IRQ_M1;

    assign converter_active = run && state_r != ST_OFF;
    assign sample_active = run && state_r == ST_SAMPLE && sample_control_r;
    assign conv_start = run && state_r == ST_SAMPLE && start;
    assign input_set_second = alternate_input_mode && alt_phase_r;

    // channel select fields vanish in 12-bit mode
    wire [15:0] chsel_rd = res12 ? 16'h0000 : chsel_r;
    wire [1:0] neg_sel = input_set_second ? chsel_rd[B_NEG_B_LO +: 2] : chsel_rd[B_NEG_A_LO +: 2];
    wire pos_sel = input_set_second ? chsel_rd[B_POS_B] : chsel_rd[B_POS_A];
    wire [4:0] oa1_an3 = op_amp_enable[0] ? SRC_OA1 : 5'h03;
    wire [4:0] oa2_an0 = op_amp_enable[1] ? SRC_OA2 : 5'h00;
    wire [4:0] oa3_an6 = op_amp_enable[2] ? SRC_OA3 : 5'h06;
    route_t route_arr [3];

    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_route
            wire [4:0] pos_one = k == 0 ? oa1_an3 : (k == 1 ? oa2_an0 : oa3_an6);
            wire [4:0] pos_zero = k == 0 ? oa2_an0 : 5'(k);
            wire [4:0] neg_ten = k == 0 ? oa3_an6 : 5'(6 + k);
            assign route_arr[k].pos = pos_sel ? pos_one : pos_zero;
            assign route_arr[k].neg = neg_sel == 2'h3 ? 5'(9 + k) :
                (neg_sel == 2'h2 ? neg_ten : SRC_VREFL);
        end
    endgenerate

    assign route_ch1 = route_arr[0];
    assign route_ch2 = route_arr[1];
    assign route_ch3 = route_arr[2];

    // output format
    wire [9:0] d10 = conv_result_raw[9:0];
    wire [11:0] d12 = conv_result_raw;
    logic [15:0] fmt;
    always_comb begin
        if (res12) begin
            case (output_format)
                2'h0: fmt = {4'h0, d12};
                2'h1: fmt = {{4{~d12[11]}}, d12};
                2'h2: fmt = {d12, 4'h0};
                default: fmt = {~d12[11], d12[10:0], 4'h0};
            endcase
        end else begin
            case (output_format)
                2'h0: fmt = {6'h00, d10};
                2'h1: fmt = {{6{~d10[9]}}, d10};
                2'h2: fmt = {d10, 6'h00};
                default: fmt = {~d10[9], d10[8:0], 6'h00};
            endcase
        end
    end

    // result addressing; 12-bit mode has one channel so its index is forced low
    wire [1:0] chan_idx = res12 ? 2'h0 : conv_result_chan;
    wire [7:0] slot = (half_r ? HALF_WORDS : 8'h00) + {6'h00, cnt_r};
    wire [7:0] sg_base = 8'(chan_idx * DMA_BUF_WORDS);
    wire [7:0] res_addr = dma_order ? slot : 8'(sg_base + slot);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (run) begin
                    state_nxt = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (!run) begin
                    state_nxt = ST_OFF;
                end else if (start) begin
                    state_nxt = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (!run) begin
                    state_nxt = ST_OFF;
                end else if (conv_result_valid) begin
                    state_nxt = ST_SAMPLE;
                end
            end
            default: state_nxt = ST_OFF;
        endcase
    end

    // hardware set beats a same-cycle software clear
    always_comb begin
        if (!run) begin
            sample_control_nxt = 1'b0;
        end else if (result_fire && auto_sample) begin
            sample_control_nxt = 1'b1;
        end else if (start) begin
            sample_control_nxt = 1'b0;
        end else if (wr_low) begin
            sample_control_nxt = wdata_r[B_SAMPLE_CONTROL];
        end else begin
            sample_control_nxt = sample_control_r;
        end
        if (result_fire) begin
            done_nxt = 1'b1;
        end else if (sw_done_clear || (run && state_r == ST_SAMPLE && start)) begin
            done_nxt = 1'b0;
        end else begin
            done_nxt = done_r;
        end
    end

    always_comb begin
        ctrl1_nxt = wr_ctrl1 ? (ctrl1_r & ~(CTRL_ONE_WMASK & byte_mask)) |
            (wdata_r & CTRL_ONE_WMASK & byte_mask) : ctrl1_r;
        ctrl2_nxt = wr_ctrl2 ? (ctrl2_r & ~(CTRL_TWO_WMASK & byte_mask)) |
            (wdata_r & CTRL_TWO_WMASK & byte_mask) : ctrl2_r;
        chsel_nxt = (wr_chsel && !res12) ? (chsel_r & ~(CHAN_SEL_WMASK & byte_mask)) |
            (wdata_r & CHAN_SEL_WMASK & byte_mask) : chsel_r;
        alt_phase_nxt = !alternate_input_mode ? 1'b0 : (result_fire ? !alt_phase_r : alt_phase_r);
        cnt_nxt = result_fire ? (irq_now ? 2'h0 : 2'(cnt_r + 2'h1)) : cnt_r;
        half_nxt = irq_now ? (buffer_fill_mode && !half_r) : half_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_OFF;
            ctrl1_r <= REG_RESET;
            ctrl2_r <= REG_RESET;
            chsel_r <= REG_RESET;
            sample_control_r <= 1'b0;
            done_r <= 1'b0;
            alt_phase_r <= 1'b0;
            half_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            chsel_r <= chsel_nxt;
            sample_control_r <= sample_control_nxt;
            done_r <= done_nxt;
            alt_phase_r <= alt_phase_nxt;
            half_r <= half_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_valid_r <= 1'b0;
            dma_r <= '0;
            irq_r <= 1'b0;
            last_r <= 16'h0000;
        end else begin
            dma_valid_r <= result_fire;
            irq_r <= irq_now;
            if (result_fire) begin
                dma_r <= '{data: fmt, addr: res_addr};
                last_r <= fmt;
            end
        end
    end

    assign dma_write_valid = dma_valid_r;
    assign dma_write = dma_r;
    assign buffer_irq = irq_r;

    // read mux; live status bits merged into control one
    wire [3:0] ra = s_axi_araddr[3:0];
    wire [15:0] ctrl1_rd = (ctrl1_r & CTRL_ONE_WMASK) | {14'h0000, sample_control_r, done_r};
    wire [15:0] rd_mux = ra == OFF_CTRL_ONE ? ctrl1_rd :
        (ra == OFF_CTRL_TWO ? ctrl2_r : (ra == OFF_CHAN_SEL ? chsel_rd : last_r));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            aw_addr_r <= 4'h0;
            aw_bad_r <= 1'b0;
            wdata_r <= 16'h0000;
            wstrb_r <= 2'h0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr[3:0];
                aw_bad_r <= aw_unmapped;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (w_fire) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata[15:0];
                wstrb_r <= s_axi_wstrb[1:0];
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= (aw_bad_r || aw_addr_r == OFF_RESULT) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= ar_unmapped ? 32'h00000000 : {16'h0000, rd_mux};
            rresp_r <= ar_unmapped ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_fire_10_int;
        result_fire && !res12 && output_format == 2'h0;
    endsequence
    sequence seq_fire_10_sint;
        result_fire && !res12 && output_format == 2'h1;
    endsequence
    sequence seq_fire_12_sfrac;
        result_fire && res12 && output_format == 2'h3;
    endsequence

    AST_OFF_HOLDS: assert property (!ctrl_on |-> !conv_start && !converter_active)
        else $error("converter active while disabled");
    AST_IDLE_STOP: assert property (idle_stop && idle_mode |-> !converter_active)
        else $error("converter runs in idle with idle-stop set");
    AST_ORDER_ADDR: assert property (result_fire && dma_order |=>
        dma_write.addr == {6'h00, $past(cnt_r)} + ($past(half_r) ? HALF_WORDS : 8'h00))
        else $error("order mode address wrong");
    AST_FMT_INT: assert property (seq_fire_10_int |=> dma_write.data[15:10] == 6'h00 &&
        dma_write.data[9:0] == $past(conv_result_raw[9:0]))
        else $error("10-bit integer format wrong");
    AST_FMT_SINT: assert property (seq_fire_10_sint |=>
        dma_write.data[15:10] == {6{~$past(conv_result_raw[9])}})
        else $error("10-bit signed integer sign fill wrong");
    AST_FMT_12_SFRAC: assert property (seq_fire_12_sfrac |=> dma_write.data[3:0] == 4'h0 &&
        dma_write.data[15] == ~$past(conv_result_raw[11]))
        else $error("12-bit signed fraction wrong");
    AST_DONE_SET: assert property (result_fire |=> done_r && dma_write_valid)
        else $error("done not set after conversion");
    AST_HALF_ALT: assert property (irq_now && buffer_fill_mode |=> half_r != $past(half_r))
        else $error("buffer half did not alternate");
    AST_BUF_RESTART: assert property (irq_now && !buffer_fill_mode |=> !half_r && cnt_r == 2'h0)
        else $error("buffer did not restart");
    AST_ALT_TOGGLE: assert property (result_fire && alternate_input_mode ##1 alternate_input_mode |->
        input_set_second != $past(input_set_second))
        else $error("input set did not alternate");
    AST_ALT_OFF: assert property (!alternate_input_mode |-> !input_set_second)
        else $error("second set used without alternate mode");
    AST_CHSEL_12B: assert property (res12 && rvalid_r == 1'b0 && s_axi_arvalid &&
        s_axi_araddr == {28'h0000000, OFF_CHAN_SEL} |=> s_axi_rdata == 32'h00000000)
        else $error("select fields visible in 12-bit mode");
    AST_OA_ROUTE: assert property (!res12 && !input_set_second && chsel_r[B_POS_A] &&
        op_amp_enable[0] |-> route_ch1.pos == SRC_OA1)
        else $error("enabled op amp not routed");
    AST_NO_DONE_OFF: assert property (!run && !done_r ##1 !sw_done_clear |-> !done_r)
        else $error("done raised while off");
endmodule

// ==== verification/adc_front_model.sv ====
`timescale 1ns/1ps
module adc_front_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic conv_start,
    input wire logic [2:0] delay,
    input wire logic [11:0] raw_in,
    input wire logic [1:0] chan_in,
    output logic conv_result_valid,
    output logic [11:0] conv_result_raw,
    output logic [1:0] conv_result_chan
);
    logic [3:0] cnt_r;
    logic [11:0] raw_r;
    logic [1:0] chan_r;
    // stale bus is inverted so a late sample never matches by luck
    assign conv_result_raw = conv_result_valid ? raw_r : ~raw_r;
    assign conv_result_chan = conv_result_valid ? chan_r : ~chan_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 4'h0;
            conv_result_valid <= 1'b0;
        end else begin
            conv_result_valid <= (cnt_r == 4'h1);
            if (conv_start) begin
                cnt_r <= {1'b0, delay} + 4'h1;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
            if (cnt_r == 4'h1) begin
                raw_r <= raw_in;
                chan_r <= chan_in;
            end
        end
    end
endmodule

// ==== verification/adc_control_and_channel_select_tb.sv ====
`timescale 1ns/1ps
module adc_control_and_channel_select_tb;
    import adc_ctrl_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, idle_mode, conv_trigger;
    logic awready, wready, bvalid, arready, rvalid, conv_start, input_set_second;
    logic dma_write_valid, buffer_irq, converter_active, res_valid, sample_active;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0] bresp, rresp, resp, chan_in, res_chan, cnt;
    logic [2:0] op_amp_enable, dly;
    logic [11:0] raw_in, res_raw;
    logic [15:0] cs, last;
    logic res, ord, buffer_fill_mode, alternate_input_mode, prev, fresh, half;
    logic [1:0] f;
    route_t route_ch1, route_ch2, route_ch3;
    result_t dma_write;
    int seed = 46, errors = 0, n_tests = 0, cyc = 0, starts = 0, k;

    adc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .idle_mode(idle_mode), .op_amp_enable(op_amp_enable), .conv_trigger(conv_trigger),
        .conv_result_valid(res_valid), .conv_result_raw(res_raw), .conv_result_chan(res_chan),
        .converter_active(converter_active), .sample_active(sample_active),
        .conv_start(conv_start),
        .input_set_second(input_set_second), .route_ch1(route_ch1), .route_ch2(route_ch2),
        .route_ch3(route_ch3), .dma_write_valid(dma_write_valid), .dma_write(dma_write),
        .buffer_irq(buffer_irq));
    adc_front_model model (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
        .delay(dly), .raw_in(raw_in), .chan_in(chan_in), .conv_result_valid(res_valid),
        .conv_result_raw(res_raw), .conv_result_chan(res_chan));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (conv_start === 1'b1) starts++;
        if (cyc == 6000) begin
            errors++;
            $display("ERROR %0t timeout", $time);
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [31:0] ad(input logic [3:0] o);
        return {28'h0, o};
    endfunction
    task automatic wr(input logic [31:0] a, input logic [15:0] d, output logic [1:0] r);
        logic ta, td;
        ta = 1'b0;
        td = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is dropped only at the edge that takes it
        while (!(ta && td)) begin
            @(posedge aclk);
            if (!ta && awready === 1'b1) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (!td && wready === 1'b1) begin
                td = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic chk_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        cmp(rdata, e, "read data");
        cmp({30'h0, rresp}, {30'h0, er}, "read resp");
    endtask
    function automatic logic [15:0] fmt(input logic r12, input logic [1:0] fm, input logic [11:0] d);
        if (r12) begin
            case (fm)
                2'h0: return {4'h0, d};
                2'h1: return {{4{~d[11]}}, d};
                2'h2: return {d, 4'h0};
                default: return {~d[11], d[10:0], 4'h0};
            endcase
        end
        case (fm)
            2'h0: return {6'h00, d[9:0]};
            2'h1: return {{6{~d[9]}}, d[9:0]};
            2'h2: return {d[9:0], 6'h00};
            default: return {~d[9], d[8:0], 6'h00};
        endcase
    endfunction
    function automatic logic [31:0] rexp(input int ch, input logic [2:0] s, input logic [2:0] oa);
        logic [4:0] p, n;
        case (ch)
            1: p = s[0] ? (oa[0] ? SRC_OA1 : 5'h03) : (oa[1] ? SRC_OA2 : 5'h00);
            2: p = s[0] ? (oa[1] ? SRC_OA2 : 5'h00) : 5'h01;
            default: p = s[0] ? (oa[2] ? SRC_OA3 : 5'h06) : 5'h02;
        endcase
        if (!s[2]) n = SRC_VREFL;
        else if (s[1]) n = 5'h08 + 5'(ch);
        else n = (ch == 1) ? (oa[2] ? SRC_OA3 : 5'h06) : 5'h05 + 5'(ch);
        return {22'h0, p, n};
    endfunction
    task automatic conv();
        int n;
        logic sec;
        logic [2:0] s;
        @(posedge aclk);
        raw_in <= res ? 12'($random(seed)) : {2'h0, 10'($random(seed))};
        chan_in <= 2'($random(seed));
        dly <= 3'($random(seed));
        conv_trigger <= 1'b1;
        n = 0;
        do begin @(negedge aclk); n++; end while (conv_start !== 1'b1 && n < 20);
        cmp({31'h0, conv_start}, 32'h1, "start");
        cmp({31'h0, sample_active}, 32'h1, "sampling");
        sec = input_set_second;
        if (alternate_input_mode && !fresh) cmp({31'h0, sec}, {31'h0, ~prev}, "alt set");
        if (!alternate_input_mode) cmp({31'h0, sec}, 32'h0, "first set");
        prev = sec;
        fresh = 1'b0;
        s = res ? 3'h0 : (sec ? cs[10:8] : cs[2:0]);
        cmp({22'h0, route_ch1}, rexp(1, s, op_amp_enable), "route1");
        cmp({22'h0, route_ch2}, rexp(2, s, op_amp_enable), "route2");
        cmp({22'h0, route_ch3}, rexp(3, s, op_amp_enable), "route3");
        @(posedge aclk);
        conv_trigger <= 1'b0;
        n = 0;
        do begin @(negedge aclk); n++; end while (dma_write_valid !== 1'b1 && n < 20);
        last = fmt(res, f, raw_in);
        cmp({16'h0, dma_write.data}, {16'h0, last}, "data");
        // one channel in 12-bit mode, so its scatter index is zero
        cmp({24'h0, dma_write.addr}, {27'h0, (ord || res) ? 2'h0 : chan_in, half, cnt},
            "addr");
        cmp({31'h0, buffer_irq}, {31'h0, cnt == 2'h3}, "irq");
        if (cnt == 2'h3) half = buffer_fill_mode && !half;
        cnt = cnt + 2'h1;
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, idle_mode, conv_trigger} = '0;
        {awaddr, wdata, araddr} = '0;
        {raw_in, chan_in, dly, op_amp_enable} = '0;
        {cnt, half} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        cmp(rexp(1, 3'h0, op_amp_enable), {22'h0, route_ch1}, "reset route");
        for (int i = 0; i < 3; i++) chk_rd(32'(4 * i), 32'h0, RESP_OKAY);
        wr(ad(OFF_CTRL_TWO), 16'hFFFF, resp);
        cmp({30'h0, resp}, {30'h0, RESP_OKAY}, "write resp");
        chk_rd(ad(OFF_CTRL_TWO), 32'h3, RESP_OKAY);
        wr(ad(OFF_CHAN_SEL), 16'hFFFF, resp);
        chk_rd(ad(OFF_CHAN_SEL), 32'h707, RESP_OKAY);
        wr(32'h10, 16'h1234, resp);
        cmp({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
        wr(ad(OFF_RESULT), 16'h1234, resp);
        cmp({30'h0, resp}, {30'h0, RESP_SLVERR}, "result write");
        chk_rd(32'h10, 32'h0, RESP_SLVERR);
        $display("register test done");
        wr(ad(OFF_CTRL_ONE), 16'h0027, resp);
        k = starts;
        conv_trigger <= 1'b1;
        repeat (10) @(posedge aclk);
        cmp(32'(starts), 32'(k), "start while off");
        cmp({31'h0, converter_active}, 32'h0, "active while off");
        cmp({31'h0, sample_active}, 32'h0, "sampling while off");
        wr(ad(OFF_CTRL_ONE), 16'hA027, resp);
        idle_mode <= 1'b1;
        repeat (10) @(posedge aclk);
        cmp(32'(starts), 32'(k), "start in idle");
        cmp({31'h0, converter_active}, 32'h0, "active in idle");
        conv_trigger <= 1'b0;
        wr(ad(OFF_CTRL_ONE), 16'h8027, resp);
        repeat (3) @(posedge aclk);
        cmp({31'h0, converter_active}, 32'h1, "run in idle");
        idle_mode <= 1'b0;
        $display("enable and idle test done");
        for (int g = 0; g < 8; g++) begin
            {f, res} = 3'(g);
            {ord, buffer_fill_mode, alternate_input_mode} = 3'($random(seed));
            cs = 16'($random(seed)) & CHAN_SEL_WMASK;
            op_amp_enable <= 3'($random(seed));
            wr(ad(OFF_CTRL_TWO), {14'h0, buffer_fill_mode, alternate_input_mode}, resp);
            // select writes are dropped in 12-bit mode, so the mode goes first
            wr(ad(OFF_CTRL_ONE), {3'h4, ord, 1'b0, res, f, 8'h27}, resp);
            wr(ad(OFF_CHAN_SEL), cs, resp);
            chk_rd(ad(OFF_CHAN_SEL), res ? 32'h0 : {16'h0, cs}, RESP_OKAY);
            fresh = 1'b1;
            repeat (8) conv();
            chk_rd(ad(OFF_CTRL_ONE), {16'h0, 3'h4, ord, 1'b0, res, f, 8'h27}, RESP_OKAY);
            chk_rd(ad(OFF_RESULT), {16'h0, last}, RESP_OKAY);
            $display("conversion group %0d done", g);
        end
        summarize();
    end
endmodule
